// ---- hw/rer_regs.vh ----
// Register map, field positions and timing constants of the regulator and reset sequencer
`ifndef RER_REGS_VH
`define RER_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RER_CTRL_ADDR 12'h000
`define RER_BATT_WARN_ADDR 12'h004
`define RER_BATT_OFF_ADDR 12'h008
`define RER_BATT_CLR_ADDR 12'h00C
`define RER_BATT_LVL_ADDR 12'h010
`define RER_STATUS_ADDR 12'h014
`define RER_WDOG_ADDR 12'h018
`define RER_KICK_ADDR 12'h01C
`define RER_DATA_ADDR 12'h020
// ----------------------------------------
// Control fields
// ----------------------------------------
`define RER_CTRL_MODE_LSB 0
`define RER_CTRL_MODE_MSB 1
`define RER_CTRL_XEN_BIT 2
`define RER_CTRL_SWRST_BIT 3
`define RER_CTRL_WDEN_BIT 4
`define RER_CTRL_XMASK_LSB 8
`define RER_CTRL_XMASK_MSB 23
`define RER_CTRL_IND_LSB 24
`define RER_CTRL_IND_MSB 27
`define RER_MODE_LATCH 2'h0
`define RER_MODE_FOLLOW 2'h1
`define RER_MODE_TOGGLE 2'h2
// ----------------------------------------
// Status fields
// ----------------------------------------
`define RER_ST_REG_ON_BIT 0
`define RER_ST_WARN_BIT 1
`define RER_ST_COLD_BIT 2
`define RER_ST_DATA_OK_BIT 3
`define RER_ST_EN_SYNC_BIT 4
`define RER_ST_BATT_OFF_BIT 5
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RER_BATT_WARN_RST 16'h0D48
`define RER_BATT_OFF_RST 16'h0CE4
`define RER_BATT_CLR_RST 16'h0FA0
`define RER_BATT_LVL_RST 16'hFFFF
`define RER_WDOG_RST 32'hFFFFFFFF
`define RER_SETTLE_US 100
`define RER_CLK_MHZ 100
`define RER_BREAK_US 1000
`endif

// ---- hw/rer_sequencer.v ----
// Regulator enable decoding, battery thresholds and reset merging with AHB-Lite registers
`include "rer_regs.vh"

// Functional notes
// - Latch mode: rising edge turns on permanently
// - Follow mode: rise turns on, fall off
// - Toggle mode: each rising edge flips state
// - Selected pin holds external regulator on
// - One-hot mask selects external regulator pin
// - Warn, shutdown, warn-clear battery thresholds
// - Pin, POR, break, watchdog all reset
// - In reset pins input, outputs tri-state
// - Warm reset keeps data; cold invalidates
// - Reset pulls: most low, RTS/CS high
// - Core POR with hysteresis from comparator
// - Module POR holds until supplies settle
module rer_sequencer #(
  parameter PIN_W = 16,                             // programmable pins
  parameter SETTLE_CYC = `RER_SETTLE_US * `RER_CLK_MHZ, // module POR settle time
  parameter BREAK_CYC = `RER_BREAK_US * `RER_CLK_MHZ    // serial break length
)(
  input wire hclk,                                  // bus clock
  input wire hresetn,                               // async reset, active low
  input wire hsel,                                  // slave select
  input wire [11:0] haddr,                          // byte address
  input wire [1:0] htrans,                          // transfer type
  input wire hwrite,                                // write strobe
  input wire [2:0] hsize,                           // transfer size
  input wire [31:0] hwdata,                         // write data
  input wire hready,                                // bus ready
  output wire hreadyout,                            // slave ready
  output wire hresp,                                // response, always okay
  output reg [31:0] hrdata,                         // read data
  input wire regulator_enable_input,                // enable pin from button
  input wire reset_pin_n,                           // external reset, active low
  input wire core_supply_low,                       // core supply below lower trip
  input wire core_supply_high,                      // core supply above upper trip
  input wire supplies_ok,                           // module supplies present
  input wire serial_rx,                             // serial receive pin level
  input wire [PIN_W-1:0] pin_out,                   // core pin output data
  input wire [PIN_W-1:0] pin_oe,                    // core pin output enables
  output reg regulators_on,                         // internal regulators enable
  output reg [PIN_W-1:0] programmable_pin_out,      // pin output data
  output reg [PIN_W-1:0] programmable_pin_oe,       // pin output enables
  output wire [PIN_W-1:0] weak_pulldown,            // pin pulldown enables
  output wire rts_weak_pullup,                      // request-to-send pullup
  output wire cs_weak_pullup,                       // chip-select pullup
  output wire rx_cts_weak_pulldown,                 // receive/clear-to-send pulldowns
  output wire audio_weak_pulldown,                  // audio interface pulldowns
  output wire device_reset_n                        // merged reset, active low
);
// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [5:0] meta_q;
reg [5:0] sync_q;
reg en_prev_q;
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    meta_q <= 6'h00;
    sync_q <= 6'h00;
    en_prev_q <= 1'b0;
  end
  else
  begin
    meta_q <= {reset_pin_n, serial_rx, supplies_ok, core_supply_high, core_supply_low,
               regulator_enable_input};
    sync_q <= meta_q;
    en_prev_q <= sync_q[0];
  end
end
wire en_s = sync_q[0];
wire en_rise = en_s & ~en_prev_q;
wire en_fall = ~en_s & en_prev_q;
// ----------------------------------------
// Registers
// ----------------------------------------
reg [31:0] ctrl_q;
reg [15:0] warn_q;
reg [15:0] off_q;
reg [15:0] clr_q;
reg [15:0] lvl_q;
reg [31:0] wdog_q;
reg [31:0] data_q;
reg data_ok_q;
reg cold_q;
reg warn_flag_q;
reg batt_off_q;
reg [31:0] wd_cnt_q;
reg [31:0] settle_q;
reg [31:0] brk_q;
reg core_por_q;
reg wr_q;
reg [11:0] addr_q;
wire [1:0] mode = ctrl_q[`RER_CTRL_MODE_MSB:`RER_CTRL_MODE_LSB];
wire [15:0] xmask = ctrl_q[`RER_CTRL_XMASK_MSB:`RER_CTRL_XMASK_LSB];
wire [3:0] ind_pin = ctrl_q[`RER_CTRL_IND_MSB:`RER_CTRL_IND_LSB];
wire wd_to = ctrl_q[`RER_CTRL_WDEN_BIT] && (wd_cnt_q >= wdog_q);
wire module_por = (settle_q < SETTLE_CYC);
wire brk = (brk_q >= BREAK_CYC);
// any source drops the merged reset
// Pin reset is synchronised like the other pins, so it acts two clocks late
wire in_reset = ~sync_q[5] | core_por_q | module_por | brk | wd_to;
assign device_reset_n = ~in_reset;
// ----------------------------------------
// AHB-Lite slave, zero wait states
// ----------------------------------------
assign hreadyout = 1'b1;
assign hresp = 1'b0;
wire take = hsel & hready & htrans[1];
function is_addr;
  input [11:0] a;
  input [11:0] r;
  begin
    is_addr = (a == r);
  end
endfunction
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    wr_q <= 1'b0;
    addr_q <= 12'h000;
    hrdata <= 32'h00000000;
  end
  else
  begin
    wr_q <= take & hwrite;
    addr_q <= haddr;
    if (take & ~hwrite)
    begin
      if (is_addr(haddr, `RER_CTRL_ADDR))
        hrdata <= ctrl_q;
      else if (is_addr(haddr, `RER_BATT_WARN_ADDR))
        hrdata <= {16'h0000, warn_q};
      else if (is_addr(haddr, `RER_BATT_OFF_ADDR))
        hrdata <= {16'h0000, off_q};
      else if (is_addr(haddr, `RER_BATT_CLR_ADDR))
        hrdata <= {16'h0000, clr_q};
      else if (is_addr(haddr, `RER_BATT_LVL_ADDR))
        hrdata <= {16'h0000, lvl_q};
      else if (is_addr(haddr, `RER_STATUS_ADDR))
        hrdata <= {26'h0000000, batt_off_q, en_s, data_ok_q, cold_q, warn_flag_q, regulators_on};
      else if (is_addr(haddr, `RER_WDOG_ADDR))
        hrdata <= wdog_q;
      else if (is_addr(haddr, `RER_DATA_ADDR))
        hrdata <= data_ok_q ? data_q : 32'h00000000;
      else
        hrdata <= 32'h00000000;
    end
  end
end
// ----------------------------------------
// Configuration, watchdog and warm/cold state
// ----------------------------------------
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    ctrl_q <= 32'h00000000;
    warn_q <= `RER_BATT_WARN_RST;
    off_q <= `RER_BATT_OFF_RST;
    clr_q <= `RER_BATT_CLR_RST;
    lvl_q <= `RER_BATT_LVL_RST;
    wdog_q <= `RER_WDOG_RST;
    data_q <= 32'h00000000;
    data_ok_q <= 1'b0;
    cold_q <= 1'b1;
    wd_cnt_q <= 32'h00000000;
  end
  else
  begin
    wd_cnt_q <= (in_reset | (wr_q & is_addr(addr_q, `RER_KICK_ADDR))) ? 32'h00000000
                : wd_cnt_q + 32'h00000001;
    // Power-on sources are cold: the cold flag sets and stored data become invalid
    if (core_por_q | module_por)
    begin
      cold_q <= 1'b1;
      data_ok_q <= 1'b0;
    end
    else if (wr_q)
    begin
      if (is_addr(addr_q, `RER_CTRL_ADDR))
        ctrl_q <= hwdata;
      else if (is_addr(addr_q, `RER_BATT_WARN_ADDR))
        warn_q <= hwdata[15:0];
      else if (is_addr(addr_q, `RER_BATT_OFF_ADDR))
        off_q <= hwdata[15:0];
      else if (is_addr(addr_q, `RER_BATT_CLR_ADDR))
        clr_q <= hwdata[15:0];
      else if (is_addr(addr_q, `RER_BATT_LVL_ADDR))
        lvl_q <= hwdata[15:0];
      else if (is_addr(addr_q, `RER_WDOG_ADDR))
        wdog_q <= hwdata;
      else if (is_addr(addr_q, `RER_DATA_ADDR))
      begin
        data_q <= hwdata;
        data_ok_q <= 1'b1;
        cold_q <= 1'b0;
      end
    end
    // Software reset bit self-clears and does not feed the merged reset
    if (ctrl_q[`RER_CTRL_SWRST_BIT] && !(wr_q && is_addr(addr_q, `RER_CTRL_ADDR)))
      ctrl_q[`RER_CTRL_SWRST_BIT] <= 1'b0;
  end
end
// ----------------------------------------
// Reset sources: POR hysteresis, settle, break
// ----------------------------------------
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    core_por_q <= 1'b1;
    settle_q <= 32'h00000000;
    brk_q <= 32'h00000000;
  end
  else
  begin
    if (sync_q[1])
      core_por_q <= 1'b1;
    else if (sync_q[2])
      core_por_q <= 1'b0;
    if (!sync_q[3])
      settle_q <= 32'h00000000;
    else if (module_por)
      settle_q <= settle_q + 32'h00000001;
    if (sync_q[4])
      brk_q <= 32'h00000000;
    else if (!brk)
      brk_q <= brk_q + 32'h00000001;
  end
end
// ----------------------------------------
// Regulator enable modes and battery thresholds
// ----------------------------------------
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    regulators_on <= 1'b0;
    warn_flag_q <= 1'b0;
    batt_off_q <= 1'b0;
  end
  else
  begin
    if (lvl_q <= warn_q)
      warn_flag_q <= 1'b1;
    else if (lvl_q >= clr_q)
      warn_flag_q <= 1'b0;
    batt_off_q <= (lvl_q <= off_q);
    if (lvl_q <= off_q)
      regulators_on <= 1'b0;
    else
      case (mode)
        `RER_MODE_LATCH: if (en_rise) regulators_on <= 1'b1;
        `RER_MODE_FOLLOW:
        begin
          if (en_rise)
            regulators_on <= 1'b1;
          else if (en_fall)
            regulators_on <= 1'b0;
        end
        `RER_MODE_TOGGLE: if (en_rise) regulators_on <= ~regulators_on;
        default: regulators_on <= regulators_on;
      endcase
  end
end
// ----------------------------------------
// Pin control: reset states and regulator hold pin
// ----------------------------------------
wire [PIN_W-1:0] xsel = xmask[PIN_W-1:0];
wire [PIN_W-1:0] ind_sel = {{(PIN_W-1){1'b0}}, 1'b1} << ind_pin;
wire xen = ctrl_q[`RER_CTRL_XEN_BIT];
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    programmable_pin_out <= {PIN_W{1'b0}};
    programmable_pin_oe <= {PIN_W{1'b0}};
  end
  else if (in_reset)
  begin
    programmable_pin_out <= {PIN_W{1'b0}};
    programmable_pin_oe <= {PIN_W{1'b0}};
  end
  else
  begin
    // The hold pin wins over core data so the module cannot power itself off
    programmable_pin_out <= (pin_out & ~(xen ? xsel : {PIN_W{1'b0}}) & ~ind_sel)
                            | (xen ? xsel : {PIN_W{1'b0}})
                            | (warn_flag_q ? ind_sel : {PIN_W{1'b0}});
    programmable_pin_oe <= pin_oe | (xen ? xsel : {PIN_W{1'b0}}) | ind_sel;
  end
end
assign weak_pulldown = in_reset ? {PIN_W{1'b1}} : {PIN_W{1'b0}};
assign rts_weak_pullup = in_reset;
assign cs_weak_pullup = in_reset;
assign rx_cts_weak_pulldown = in_reset;
assign audio_weak_pulldown = in_reset;
endmodule

// ---- bench/rer_sequencer_assertions.sv ----
// Port-level checks for the regulator and reset sequencer
`include "rer_regs.vh"
module rer_sequencer_assertions #(
  parameter PIN_W = 16,
  parameter BREAK_CYC = 16
)(
  input wire hclk, // clock
  input wire hresetn, // bus reset
  input wire hsel, // select
  input wire [11:0] haddr, // address
  input wire [1:0] htrans, // type
  input wire hwrite, // write
  input wire [31:0] hwdata, // data
  input wire regulator_enable_input, // enable pin
  input wire reset_pin_n, // reset pin
  input wire core_supply_low, // core low
  input wire supplies_ok, // supplies
  input wire serial_rx, // rx line
  input wire regulators_on, // regulators
  input wire [PIN_W-1:0] programmable_pin_out, // pins
  input wire [PIN_W-1:0] programmable_pin_oe, // enables
  input wire [PIN_W-1:0] weak_pulldown, // pulls
  input wire rts_weak_pullup, // rts pull
  input wire cs_weak_pullup, // cs pull
  input wire device_reset_n // merged reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wp_q;
  logic [11:0] wa_q;
  logic [31:0] ctl_q;
  int rxc_q;
  wire en = regulator_enable_input;
  wire ron = regulators_on;
  wire dr = device_reset_n;
  wire [1:0] md = ctl_q[1:0];
  wire [PIN_W-1:0] msk = ctl_q[8 +: PIN_W];
  // Shadow of the control word, so mode checks need no internal probe
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wp_q <= 1'h0;
      wa_q <= 12'h0;
      ctl_q <= 32'h0;
      rxc_q <= 0;
    end
    else
    begin
      wp_q <= hsel & htrans[1] & hwrite;
      wa_q <= haddr;
      if (wp_q && wa_q == `RER_CTRL_ADDR)
        ctl_q <= hwdata;
      rxc_q <= serial_rx ? 0 : rxc_q + 1;
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_latch; $fell(en) && dr && $past(dr) && md == 2'h0 && ron |=> ron [*6]; endproperty
  a_latch: assert property (p_latch) else $error("latched regulators dropped");
  property p_follow_on; $rose(en) && dr && $past(dr) && md == 2'h1 |-> ##[2:6] ron; endproperty
  a_follow_on: assert property (p_follow_on) else $error("follow rise missed");
  property p_follow_off; $fell(en) && dr && $past(dr) && md == 2'h1 |-> ##[2:6] !ron; endproperty
  a_follow_off: assert property (p_follow_off) else $error("follow fall missed");
  property p_toggle; $rose(en) && dr && $past(dr) && md == 2'h2 && ron |-> ##[2:6] !ron; endproperty
  a_toggle: assert property (p_toggle) else $error("toggle off missed");
  property p_hold;
    (ctl_q[2] && dr && $stable(ctl_q)) [*3] |->
      (programmable_pin_out & programmable_pin_oe & msk) == msk;
  endproperty
  a_hold: assert property (p_hold) else $error("hold pin not driven");
  property p_tri; !dr [*2] |-> programmable_pin_oe == '0; endproperty
  a_tri: assert property (p_tri) else $error("pin driven in reset");
  property p_pulls;
    weak_pulldown == {PIN_W{!dr}} && rts_weak_pullup == !dr && cs_weak_pullup == !dr;
  endproperty
  a_pulls: assert property (p_pulls) else $error("reset pulls wrong");
  property p_pin; !reset_pin_n [*3] |-> !dr; endproperty
  a_pin: assert property (p_pin) else $error("pin reset ignored");
  property p_brk; rxc_q > BREAK_CYC + 6 |-> !dr; endproperty
  a_brk: assert property (p_brk) else $error("break reset missed");
  property p_core; core_supply_low [*4] |-> !dr; endproperty
  a_core: assert property (p_core) else $error("core reset missed");
  property p_settle; $rose(supplies_ok) |-> !dr [*8]; endproperty
  a_settle: assert property (p_settle) else $error("settle time short");
endmodule
bind rer_sequencer rer_sequencer_assertions #(.PIN_W(PIN_W), .BREAK_CYC(BREAK_CYC)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .regulator_enable_input(regulator_enable_input),
  .reset_pin_n(reset_pin_n), .core_supply_low(core_supply_low), .supplies_ok(supplies_ok),
  .serial_rx(serial_rx), .regulators_on(regulators_on),
  .programmable_pin_out(programmable_pin_out), .programmable_pin_oe(programmable_pin_oe),
  .weak_pulldown(weak_pulldown), .rts_weak_pullup(rts_weak_pullup),
  .cs_weak_pullup(cs_weak_pullup), .device_reset_n(device_reset_n));

// ---- bench/rer_partner.sv ----
// Far side: power button, host reset driver and serial host
module rer_partner (
  input wire hclk, // clock
  input wire btn, // button held
  input wire host_rst, // host holds reset
  input wire brk, // host sends break
  input wire device_reset_n, // merged reset
  output wire regulator_enable_input, // enable pin
  output logic reset_pin_n = 1'h1, // reset pin
  output logic serial_rx = 1'h1 // rx, idles high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic btn_q = 1'h0;
  always @(posedge hclk)
  begin
    btn_q <= btn;
    reset_pin_n <= !host_rst;
    serial_rx <= !brk;
  end
  // Enable held high through any reset, else the module powers itself off
  assign regulator_enable_input = btn_q | !reset_pin_n | !device_reset_n;
endmodule

// ---- bench/test_regulator_enable_and_reset.sv ----
// Self-checking bench for the regulator and reset sequencer
`include "rer_regs.vh"
module test_regulator_enable_and_reset;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rdv;
  logic [15:0] pin_out = 16'h0, pin_oe = 16'h0, lf_q = 16'h003C;
  logic [15:0] po_q = 16'h0, pe_q = 16'h0;
  logic btn = 1'h0, host_rst = 1'h0, brk = 1'h0, sok = 1'h1, clo = 1'h0, chi = 1'h1;
  wire hready, hresp, en, rst_n, rx, ron, dr, rts, cs, rxp, aup;
  wire [31:0] hrdata;
  wire [15:0] p_out, p_oe, pd;
  int n_fail = 0, n_checks = 0, m_on = 0, md;
  logic [31:0] m_data;
  always #5 hclk = ~hclk;
  rer_sequencer #(.PIN_W(16), .SETTLE_CYC(8), .BREAK_CYC(16)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .regulator_enable_input(en), .reset_pin_n(rst_n),
    .core_supply_low(clo), .core_supply_high(chi), .supplies_ok(sok), .serial_rx(rx),
    .pin_out(pin_out), .pin_oe(pin_oe), .regulators_on(ron), .programmable_pin_out(p_out),
    .programmable_pin_oe(p_oe), .weak_pulldown(pd), .rts_weak_pullup(rts),
    .cs_weak_pullup(cs), .rx_cts_weak_pulldown(rxp), .audio_weak_pulldown(aup),
    .device_reset_n(dr));
  rer_partner u_far (.hclk(hclk), .btn(btn), .host_rst(host_rst), .brk(brk),
    .device_reset_n(dr), .regulator_enable_input(en), .reset_pin_n(rst_n), .serial_rx(rx));
  // ----------
  // Tasks
  // ----------
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wrdy;
    int i;
    i = 0;
    do
      @(posedge hclk);
    while (hready !== 1'h1 && ++i < 50);
    if (hready !== 1'h1)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wrdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy;
    rdv = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    bus(1'h0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  task automatic wdr(input logic v);
    for (int i = 0; i < 300 && dr !== v; i++)
      @(posedge hclk);
    chk("device_reset_n", v, dr);
    if (dr !== v)
      tally_and_finish;
  endtask
  // Reference model of the enable decoder
  task automatic press(input logic lvl);
    btn <= lvl;
    if (md == 2)
      m_on = lvl ? 1 - m_on : m_on;
    else if (lvl || md == 1)
      m_on = lvl;
    cyc(10);
    chk("regulators_on", m_on, ron);
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  always @(posedge hclk)
  begin
    lf_q <= lfsr(lf_q);
    pin_out <= lf_q;
    pin_oe <= ~lf_q;
    po_q <= pin_out;
    pe_q <= pin_oe;
  end
  // ----------
  // Sequence
  // ----------
  initial
  begin
    cyc(20);
    hresetn <= 1'h1;
    wdr(1'h1);
    rd(`RER_BATT_WARN_ADDR, {16'h0, `RER_BATT_WARN_RST}, "warn");
    rd(`RER_BATT_OFF_ADDR, {16'h0, `RER_BATT_OFF_RST}, "off");
    rd(`RER_BATT_CLR_ADDR, {16'h0, `RER_BATT_CLR_RST}, "clear");
    rd(`RER_DATA_ADDR, 32'h0, "data");
    rd(12'h040, 32'h0, "unmapped");
    for (int k = 0; k < 3; k++)
    begin
      md = (k + 1) % 3;
      bus(1'h1, `RER_CTRL_ADDR, 32'h0404 | md);
      repeat (2)
      begin
        press(1'h1);
        press(1'h0);
      end
    end
    chk("hold pin", 32'h3, {p_out[2], p_oe[2]});
    bus(1'h1, `RER_BATT_LVL_ADDR, {16'h0, `RER_BATT_OFF_RST});
    cyc(4);
    chk("battery off", 32'h0, ron);
    bus(1'h0, `RER_STATUS_ADDR, 32'h0);
    chk("warn flag", 32'h1, rdv[`RER_ST_WARN_BIT]);
    chk("indicator", 32'h1, p_out[0]);
    bus(1'h1, `RER_BATT_LVL_ADDR, {16'h0, `RER_BATT_CLR_RST});
    cyc(4);
    chk("indicator", 32'h0, p_out[0]);
    bus(1'h1, `RER_CTRL_ADDR, 32'h0);
    cyc(2);
    chk("pin data", {po_q & 16'hFFFE, pe_q | 16'h0001}, {p_out, p_oe});
    m_data = {lf_q, ~lf_q};
    bus(1'h1, `RER_DATA_ADDR, m_data);
    host_rst <= 1'h1;
    wdr(1'h0);
    cyc(2);
    chk("pulls", 32'hFFFFF, {pd, rts, cs, rxp, aup});
    chk("oe", 32'h0, p_oe);
    host_rst <= 1'h0;
    wdr(1'h1);
    brk <= 1'h1;
    wdr(1'h0);
    cyc(10);
    brk <= 1'h0;
    wdr(1'h1);
    bus(1'h1, `RER_WDOG_ADDR, 32'h20);
    bus(1'h1, `RER_CTRL_ADDR, 32'h10);
    wdr(1'h0);
    bus(1'h1, `RER_CTRL_ADDR, 32'h0);
    wdr(1'h1);
    rd(`RER_DATA_ADDR, m_data, "data warm");
    clo <= 1'h1;
    chi <= 1'h0;
    wdr(1'h0);
    cyc(3);
    clo <= 1'h0;
    chi <= 1'h1;
    wdr(1'h1);
    rd(`RER_DATA_ADDR, 32'h0, "data cold");
    sok <= 1'h0;
    cyc(6);
    sok <= 1'h1;
    cyc(5);
    chk("settle", 32'h0, dr);
    wdr(1'h1);
    tally_and_finish;
  end
  initial
  begin
    cyc(100000);
    n_fail++;
    tally_and_finish;
  end
endmodule
